// ### design/slc_cal_enh_regs.sv
// calibration result and enhancement enable registers with the logic they steer
`timescale 1ns/1ns
// Notes on behaviour
// - dac offset result: eight read/write bits, zero after reset
// - common mode result: six bits, top two bits read zero
// - dc peak monitor result: four read/write bits, top four read zero
// - boost bit raises current limit to 41 mA after ring burst, else programmed
// - fsk bit: 24 kHz tone clock and fsk oscillators only while ringing select set
// - fsk bit clear: tone clock always 8 kHz, standard oscillator registers
// - at the fast rate, oscillator timers tick every 41.66 us
// - speedup bit, in the converter variant only, selects multi-threshold converter control, else normal
// - impedance reference bit disconnects internal reference resistor
// - debounce bit, in the external battery variant only, with external batteries delays high-to-low switch 60 ms
// - voltage loop closure bit uses tip-ring voltage, else loop current
// - squelch bit, in the converter variant only, suppresses converter noise in voice band, else off
// - hysteresis bit: upper threshold index 28, lower index 43
// - enhancement enables all reset to zero
module slc_cal_enh_regs import slc_pkg::*; #(
	parameter bit HAS_CONVERTER = 1'b1,
	parameter int unsigned DEBOUNCE_CYCLES = SLC_DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// register access from the control port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// calibration results to the analog trims
	output logic [7:0] dac_offset_result,
	output logic [5:0] common_mode_balance_result,
	output logic [3:0] dc_peak_monitor_result,
	// linefeed current limit
	input wire logic ring_burst_end,
	input wire logic dc_feed_settled,
	input wire logic [5:0] programmed_current_limit,
	output logic [5:0] current_limit_ma,
	// tone generator one
	input wire logic ringing_select_bit,
	output logic tone_clk_en,
	output logic fsk_osc_select,
	// battery switching
	input wire logic external_battery_select,
	input wire logic battery_low_request,
	output logic battery_low_select,
	// loop closure and converter controls
	input wire logic loop_closed_state,
	output logic [5:0] lc_threshold_index,
	output logic converter_multi_threshold,
	output logic impedance_ref_internal_off,
	output logic loop_closure_by_voltage,
	output logic converter_squelch_on,
	output logic loop_closure_hysteresis_on
);

	// =====================================================
	// state
	slc_state_t s;
	slc_state_t next_s;
	slc_req_t req;
	logic [7:0] enh_mask;

	assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
	assign enh_mask = HAS_CONVERTER ? SLC_ENH_MASK_CONVERTER : SLC_ENH_MASK_EXT_BATTERY;

	function automatic logic [7:0] read_mux(input slc_state_t st, input logic [7:0] a);
		logic [7:0] r;
		r = SLC_UNMAPPED_READ;
		if (a == SLC_OFS_DAC_OFFSET) begin
			r = st.dac_offset_result;
		end else if (a == SLC_OFS_COMMON_MODE) begin
			r = {2'b00, st.common_mode_balance_result};
		end else if (a == SLC_OFS_DC_PEAK) begin
			r = {4'h0, st.dc_peak_monitor_result};
		end else if (a == SLC_OFS_ENHANCE) begin
			r = st.enh;
		end
		return r;
	endfunction : read_mux

	// =====================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.rvalid = req.rd;
		if (req.rd) begin
			next_s.rdata = read_mux(s, req.addr);
		end
		if (req.wr) begin
			if (req.addr == SLC_OFS_DAC_OFFSET) begin
				next_s.dac_offset_result = req.wdata;
			end else if (req.addr == SLC_OFS_COMMON_MODE) begin
				next_s.common_mode_balance_result = req.wdata[SLC_CM_W-1:0];
			end else if (req.addr == SLC_OFS_DC_PEAK) begin
				next_s.dc_peak_monitor_result = req.wdata[SLC_PK_W-1:0];
			end else if (req.addr == SLC_OFS_ENHANCE) begin
				next_s.enh = req.wdata & enh_mask;
			end
		end
		// boost holds from burst end until feed settles; a new burst end wins
		if (!s.enh.current_limit_boost_enable) begin
			next_s.boost = 1'b0;
		end else if (ring_burst_end) begin
			next_s.boost = 1'b1;
		end else if (dc_feed_settled) begin
			next_s.boost = 1'b0;
		end
		next_s.programmed_current_limit_ma = next_s.boost ? SLC_PROGRAMMED_CURRENT_LIMIT_BOOST_MA : programmed_current_limit;
		// tone clock divider, rate chosen each period
		next_s.fsk_sel = s.enh.fsk_rate_enhance_enable && ringing_select_bit;
		next_s.tone_tick = (s.tone_div == '0);
		if (s.tone_div == '0) begin
			next_s.tone_div = s.fsk_sel ? SLC_TONE_DIV_W'(SLC_TONE_FAST_CYCLES - 1)
				: SLC_TONE_DIV_W'(SLC_TONE_SLOW_CYCLES - 1);
		end else begin
			next_s.tone_div = s.tone_div - 1'b1;
		end
		// only the switch toward the low battery is debounced
		if (!battery_low_request) begin
			next_s.bat_low = 1'b0;
			next_s.deb_cnt = '0;
		end else if (!(s.enh.battery_switch_debounce_enable && external_battery_select)) begin
			next_s.bat_low = 1'b1;
			next_s.deb_cnt = '0;
		end else if (!s.bat_low) begin
			if (s.deb_cnt >= SLC_DEBOUNCE_W'(DEBOUNCE_CYCLES - 1)) begin
				next_s.bat_low = 1'b1;
				next_s.deb_cnt = '0;
			end else begin
				next_s.deb_cnt = s.deb_cnt + 1'b1;
			end
		end
		// with hysteresis enabled, a closed loop watches for release at the lower threshold
		if (s.enh.loop_closure_hysteresis_enable && loop_closed_state) begin
			next_s.lc_thr = SLC_LC_LOWER_INDEX;
		end else begin
			next_s.lc_thr = SLC_LC_UPPER_INDEX;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.dac_offset_result <= SLC_RST_DAC_OFFSET;
			s.common_mode_balance_result <= SLC_RST_COMMON_MODE;
			s.dc_peak_monitor_result <= SLC_RST_DC_PEAK;
			s.enh <= SLC_RST_ENHANCE;
			s.programmed_current_limit_ma <= 6'h00;
			s.lc_thr <= SLC_LC_UPPER_INDEX;
		end else begin
			s <= next_s;
		end
	end

	// =====================================================
	// outputs
	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign dac_offset_result = s.dac_offset_result;
	assign common_mode_balance_result = s.common_mode_balance_result;
	assign dc_peak_monitor_result = s.dc_peak_monitor_result;
	assign current_limit_ma = s.programmed_current_limit_ma;
	assign tone_clk_en = s.tone_tick;
	assign fsk_osc_select = s.fsk_sel;
	assign battery_low_select = s.bat_low;
	assign lc_threshold_index = s.lc_thr;
	assign converter_multi_threshold = s.enh.converter_speedup_enable;
	assign impedance_ref_internal_off = s.enh.impedance_ref_disable;
	assign loop_closure_by_voltage = s.enh.voltage_loop_closure_enable;
	assign converter_squelch_on = s.enh.converter_squelch_enable;
	assign loop_closure_hysteresis_on = s.enh.loop_closure_hysteresis_enable;

	// =====================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_dac_write_read: assert property (
		(reg_wr && reg_addr == SLC_OFS_DAC_OFFSET) ##1
		(reg_rd && !reg_wr && reg_addr == SLC_OFS_DAC_OFFSET)
		|=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
		else $error("dac offset did not read back");
	a_cm_upper_zero: assert property (
		reg_rd && reg_addr == SLC_OFS_COMMON_MODE |=> reg_rdata[7:6] == 2'b00)
		else $error("common mode upper bits not zero");
	a_peak_upper_zero: assert property (
		reg_rd && reg_addr == SLC_OFS_DC_PEAK |=> reg_rdata[7:4] == 4'h0)
		else $error("dc peak upper bits not zero");
	a_enh_after_reset: assert property (
		$rose(resetn) |-> s.enh == SLC_RST_ENHANCE)
		else $error("enhancement enables not cleared");
	a_boost_limit: assert property (
		s.enh.current_limit_boost_enable && ring_burst_end |=> current_limit_ma == SLC_PROGRAMMED_CURRENT_LIMIT_BOOST_MA)
		else $error("current limit not raised");
	a_normal_limit: assert property (
		!s.enh.current_limit_boost_enable && !reg_wr |=> current_limit_ma == $past(programmed_current_limit))
		else $error("programmed limit not used");
	a_fsk_select: assert property (
		1'b1 |=> fsk_osc_select == $past(s.enh.fsk_rate_enhance_enable && ringing_select_bit))
		else $error("fsk oscillator select wrong");
	a_tone_period: assert property (
		tone_clk_en |-> s.tone_div == ($past(s.fsk_sel) ? SLC_TONE_DIV_W'(SLC_TONE_FAST_CYCLES - 1)
			: SLC_TONE_DIV_W'(SLC_TONE_SLOW_CYCLES - 1)))
		else $error("tone clock period wrong");
	a_bat_release: assert property (
		!battery_low_request |=> !battery_low_select)
		else $error("battery release delayed");
	a_bat_no_debounce: assert property (
		battery_low_request && !(s.enh.battery_switch_debounce_enable && external_battery_select)
		|=> battery_low_select)
		else $error("undebounced switch delayed");
	a_hyst_lower: assert property (
		s.enh.loop_closure_hysteresis_enable && loop_closed_state |=> lc_threshold_index == SLC_LC_LOWER_INDEX)
		else $error("lower hysteresis threshold not used");

	c_boost_seen: cover property (ring_burst_end ##1 current_limit_ma == SLC_PROGRAMMED_CURRENT_LIMIT_BOOST_MA);
	c_fast_tone: cover property (fsk_osc_select && tone_clk_en);
	c_debounced_low: cover property (s.enh.battery_switch_debounce_enable && $rose(battery_low_select));

endmodule : slc_cal_enh_regs

// ### design/slc_pkg.sv
// constants and types for the calibration and enhancement register bank
package slc_pkg;

	// =====================================================
	// register offsets
	localparam logic [7:0] SLC_OFS_DAC_OFFSET = 8'h69;
	localparam logic [7:0] SLC_OFS_COMMON_MODE = 8'h6A;
	localparam logic [7:0] SLC_OFS_DC_PEAK = 8'h6B;
	localparam logic [7:0] SLC_OFS_ENHANCE = 8'h6C;

	// =====================================================
	// field widths and reset values
	localparam int SLC_DAC_W = 8;
	localparam int SLC_CM_W = 6;
	localparam int SLC_PK_W = 4;
	localparam logic [7:0] SLC_RST_DAC_OFFSET = 8'h00;
	localparam logic [5:0] SLC_RST_COMMON_MODE = 6'h00;
	localparam logic [3:0] SLC_RST_DC_PEAK = 4'h0;
	localparam logic [7:0] SLC_RST_ENHANCE = 8'h00;
	localparam logic [7:0] SLC_UNMAPPED_READ = 8'h00;

	// implemented enhancement bits per variant
	localparam logic [7:0] SLC_ENH_MASK_CONVERTER = 8'hF7;
	localparam logic [7:0] SLC_ENH_MASK_EXT_BATTERY = 8'hDD;

	// =====================================================
	// timing
	localparam int unsigned SLC_CLK_HZ = 50_000_000;
	localparam int unsigned SLC_TONE_FAST_HZ = 24_000;
	localparam int unsigned SLC_TONE_SLOW_HZ = 8_000;
	localparam int unsigned SLC_TONE_FAST_CYCLES = SLC_CLK_HZ / SLC_TONE_FAST_HZ;
	localparam int unsigned SLC_TONE_SLOW_CYCLES = SLC_CLK_HZ / SLC_TONE_SLOW_HZ;
	localparam int SLC_TONE_DIV_W = 13;
	localparam int unsigned SLC_DEBOUNCE_MS = 60;
	localparam int unsigned SLC_DEBOUNCE_CYCLES = SLC_CLK_HZ / 1000 * SLC_DEBOUNCE_MS;
	localparam int SLC_DEBOUNCE_W = 22;

	// =====================================================
	// feature values
	localparam logic [5:0] SLC_PROGRAMMED_CURRENT_LIMIT_BOOST_MA = 6'd41;
	localparam logic [5:0] SLC_LC_UPPER_INDEX = 6'd28;
	localparam logic [5:0] SLC_LC_LOWER_INDEX = 6'd43;

	// enhancement enable layout, bit 7 first
	typedef struct packed {
		logic current_limit_boost_enable;
		logic fsk_rate_enhance_enable;
		logic converter_speedup_enable;
		logic impedance_ref_disable;
		logic battery_switch_debounce_enable;
		logic voltage_loop_closure_enable;
		logic converter_squelch_enable;
		logic loop_closure_hysteresis_enable;
	} slc_enh_t;

	// register access request from the control port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} slc_req_t;

	// whole state of the bank
	typedef struct packed {
		logic [SLC_DAC_W-1:0] dac_offset_result;
		logic [SLC_CM_W-1:0] common_mode_balance_result;
		logic [SLC_PK_W-1:0] dc_peak_monitor_result;
		slc_enh_t enh;
		logic [7:0] rdata;
		logic rvalid;
		logic boost;
		logic [5:0] programmed_current_limit_ma;
		logic [SLC_TONE_DIV_W-1:0] tone_div;
		logic tone_tick;
		logic fsk_sel;
		logic bat_low;
		logic [SLC_DEBOUNCE_W-1:0] deb_cnt;
		logic [5:0] lc_thr;
	} slc_state_t;

endpackage : slc_pkg

// ### verification/tb.sv
// self-checking bench for the calibration and enhancement register bank
`timescale 1ns/1ns
module tb;
	import slc_pkg::*;
	// ==========================================
	// stimulus and observed signals
	logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ring_burst_end = 1'b0, dc_feed_settled = 1'b0;
	logic ringing_select_bit = 1'b0, external_battery_select = 1'b0, battery_low_request = 1'b0;
	logic loop_closed_state = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dac_offset_result, v, a;
	logic [5:0] programmed_current_limit = 6'h14, common_mode_balance_result, current_limit_ma, lc_threshold_index;
	logic [3:0] dc_peak_monitor_result;
	logic reg_rvalid, tone_clk_en, fsk_osc_select, battery_low_select, converter_multi_threshold;
	logic impedance_ref_internal_off, loop_closure_by_voltage, converter_squelch_on, loop_closure_hysteresis_on;
	logic [7:0] shadow [4];
	int err_total = 0, samples_checked = 0, cycles = 0, seed = 93;
	slc_cal_enh_regs #(.HAS_CONVERTER(1'b1), .DEBOUNCE_CYCLES(20)) slc_cal_enh_regs_i (.clk_sys(clk_sys),
		.resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_offset_result(dac_offset_result),
		.common_mode_balance_result(common_mode_balance_result), .dc_peak_monitor_result(dc_peak_monitor_result),
		.ring_burst_end(ring_burst_end), .dc_feed_settled(dc_feed_settled),
		.programmed_current_limit(programmed_current_limit), .current_limit_ma(current_limit_ma),
		.ringing_select_bit(ringing_select_bit), .tone_clk_en(tone_clk_en), .fsk_osc_select(fsk_osc_select),
		.external_battery_select(external_battery_select), .battery_low_request(battery_low_request),
		.battery_low_select(battery_low_select), .loop_closed_state(loop_closed_state),
		.lc_threshold_index(lc_threshold_index), .converter_multi_threshold(converter_multi_threshold),
		.impedance_ref_internal_off(impedance_ref_internal_off), .loop_closure_by_voltage(loop_closure_by_voltage),
		.converter_squelch_on(converter_squelch_on), .loop_closure_hysteresis_on(loop_closure_hysteresis_on));
	// ==========================================
	// clock, hang guard and helpers
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			err_total++;
			test_done();
		end
	end
	function automatic logic [7:0] field_mask(input logic [7:0] ofs);
		case (ofs)
			8'h69: return 8'hFF;
			8'h6A: return 8'h3F;
			8'h6B: return 8'h0F;
			8'h6C: return 8'hF7;
			default: return 8'h00;
		endcase
	endfunction : field_mask
	function automatic int tone_cycles(input logic fast);
		return fast ? 50_000_000 / 24_000 : 50_000_000 / 8_000;
	endfunction : tone_cycles
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= ofs;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
		if (field_mask(ofs) !== 8'h00) shadow[ofs - 8'h69] = d & field_mask(ofs);
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= ofs;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
		chk("rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask : rd
	task automatic strobe(input logic settle);
		@(posedge clk_sys);
		if (settle) dc_feed_settled <= 1'b1;
		else ring_burst_end <= 1'b1;
		@(posedge clk_sys);
		dc_feed_settled <= 1'b0;
		ring_burst_end <= 1'b0;
		#1;
	endtask : strobe
	task automatic period(input int exp);
		int n;
		n = 0;
		while (tone_clk_en !== 1'b1 && n < 7000) begin
			cyc(1);
			n++;
		end
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (tone_clk_en !== 1'b1 && n < 7000);
		chk("tone period", exp[15:0], n[15:0]);
	endtask : period
	task automatic check_fields();
		chk("dac field", {8'h00, shadow[0]}, {8'h00, dac_offset_result});
		chk("cm field", {8'h00, shadow[1]}, {10'h000, common_mode_balance_result});
		chk("pk field", {8'h00, shadow[2]}, {12'h000, dc_peak_monitor_result});
		chk("enh copies", {11'h000, shadow[3][5], shadow[3][4], shadow[3][2:0]}, {11'h000, converter_multi_threshold,
			impedance_ref_internal_off, loop_closure_by_voltage, converter_squelch_on, loop_closure_hysteresis_on});
	endtask : check_fields
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// ==========================================
	// main sequence
	initial begin
		for (int i = 0; i < 4; i++) shadow[i] = 8'h00;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(8'h68 + i[7:0], 8'h00);
		chk("lc index", 16'd28, {10'h000, lc_threshold_index});
		$display("test reset values done");
		for (int k = 0; k < 28; k++) begin
			a = (k < 4) ? 8'h69 + k[7:0] : 8'h69 + 8'($random(seed) & 3);
			v = (k < 4) ? 8'hFF : 8'($random(seed));
			wr(a, v);
			check_fields();
			wr(8'h6D, ~v);
			rd(a, shadow[a - 8'h69]);
		end
		$display("test register access done");
		wr(8'h6C, 8'h80);
		programmed_current_limit <= 6'($random(seed) & 32'h1F);
		cyc(3);
		chk("limit", {10'h000, programmed_current_limit}, {10'h000, current_limit_ma});
		strobe(1'b0);
		chk("boost", {10'h000, SLC_PROGRAMMED_CURRENT_LIMIT_BOOST_MA}, {10'h000, current_limit_ma});
		cyc(3);
		chk("boost held", 16'd41, {10'h000, current_limit_ma});
		strobe(1'b1);
		chk("limit back", {10'h000, programmed_current_limit}, {10'h000, current_limit_ma});
		wr(8'h6C, 8'h00);
		strobe(1'b0);
		chk("no boost", {10'h000, programmed_current_limit}, {10'h000, current_limit_ma});
		$display("test current limit done");
		for (int k = 3; k > 0; k--) begin
			wr(8'h6C, k[1] ? 8'h40 : 8'h00);
			@(posedge clk_sys);
			ringing_select_bit <= k[0] | ~k[1];
			cyc(2);
			chk("fsk select", {15'h0000, k == 3}, {15'h0000, fsk_osc_select});
			period(tone_cycles(k == 3));
		end
		$display("test tone rate done");
		for (int k = 0; k < 4; k++) begin
			wr(8'h6C, {7'h00, k[1]});
			@(posedge clk_sys);
			loop_closed_state <= k[0];
			cyc(2);
			chk("lc index", (k == 3) ? 16'd43 : 16'd28, {10'h000, lc_threshold_index});
		end
		$display("test hysteresis done");
		wr(8'h6C, 8'h08);
		rd(8'h6C, 8'h00);
		@(posedge clk_sys);
		external_battery_select <= 1'b1;
		battery_low_request <= 1'b1;
		cyc(2);
		chk("battery low", 16'h0001, {15'h0000, battery_low_select});
		battery_low_request <= 1'b0;
		cyc(2);
		chk("battery high", 16'h0000, {15'h0000, battery_low_select});
		$display("test battery done");
		wr(8'h69, 8'h5A);
		wr(8'h6C, 8'hF7);
		@(posedge clk_sys);
		resetn <= 1'b0;
		cyc(2);
		resetn <= 1'b1;
		for (int i = 0; i < 4; i++) shadow[i] = 8'h00;
		check_fields();
		for (int i = 0; i < 4; i++) rd(8'h69 + i[7:0], 8'h00);
		$display("test mid-run reset done");
		test_done();
	end
endmodule : tb
